/* File: logic/rlsc_top.sv */
`timescale 1ns/1ps
module rlsc_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus: write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // register bus: write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // register bus: write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // register bus: read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // register bus: read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // core memory request
    input  wire logic        core_req,
    input  wire logic        core_we,
    input  wire logic        core_user,
    input  wire logic [31:0] core_addr,
    input  wire logic [3:0]  core_be,
    input  wire logic [31:0] core_wdata,
    // core memory answer for local hits
    output logic             core_ack,
    output logic             core_abort,
    output logic [31:0]      core_rdata,
    // segment table, flattened, segment n at slice n
    input  wire logic [175:0] seg_start,
    input  wire logic [175:0] seg_stop,
    input  wire logic [127:0] segment_descriptor,
    input  wire logic [15:0]  fallback_segment_descriptor,
    // cache in plain-memory mode
    input  wire logic        cache_plain_mode,
    output logic             cache_plain_sel,
    // external bus path
    output logic             ext_req,
    output logic             ext_we,
    output logic [31:0]      ext_addr,
    output logic [3:0]       ext_be,
    output logic [31:0]      ext_wdata,
    output logic             ext_no_alloc,
    // status
    output logic             local_enabled,
    output logic             local_high
);

    localparam int PB = rlsc_pkg::PAGE_BITS;
    localparam int DW = rlsc_pkg::DESC_WIDTH;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    function automatic logic in_window(input logic [31:0] a,
                                       input logic [31:0] base);
        in_window = (a[31:rlsc_pkg::WIN_SHIFT] ==
                     base[31:rlsc_pkg::WIN_SHIFT]);
    endfunction

    // only the four privilege bits are looked at
    function automatic logic priv_ok(input logic [DW-1:0] d,
                                     input logic user,
                                     input logic we);
        if (user && !we) begin
            priv_ok = d[rlsc_pkg::PRIV_USER_RD];
        end else if (user) begin
            priv_ok = d[rlsc_pkg::PRIV_USER_WR];
        end else if (!we) begin
            priv_ok = d[rlsc_pkg::PRIV_SYS_RD];
        end else begin
            priv_ok = d[rlsc_pkg::PRIV_SYS_WR];
        end
    endfunction

    function automatic logic is_ctrl(input logic [31:0] a);
        is_ctrl = (a == rlsc_pkg::CTRL_BASE_ADDR + rlsc_pkg::CTRL_OFFSET);
    endfunction

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    logic [rlsc_pkg::CTRL_WIDTH-1:0] ctrl_ff;
    logic                            ctrl_wr;
    logic [31:0]                     awaddr_ff;
    logic [31:0]                     wdata_ff;
    logic [3:0]                      wstrb_ff;
    logic                            aw_held_ff;
    logic                            w_held_ff;

    // both halves of a write present, no response pending
    assign ctrl_wr = aw_held_ff && w_held_ff && !s_axi_bvalid;

    // a write without the byte 0 strobe leaves the register as is
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= rlsc_pkg::CTRL_RESET;
        end else if (ctrl_wr && is_ctrl(awaddr_ff) && wstrb_ff[0]) begin
            // reserved bits 7:2 cannot be set
            ctrl_ff <= wdata_ff[7:0] & rlsc_pkg::CTRL_WRITE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // register bus write side
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= 32'h0000_0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (ctrl_wr) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
        end else if (ctrl_wr) begin
            w_held_ff <= 1'b0;
        end
    end

    // each channel ready while its holding slot is free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !(aw_held_ff || (s_axi_awvalid && s_axi_awready))
                             || ctrl_wr;
            s_axi_wready  <= !(w_held_ff || (s_axi_wvalid && s_axi_wready))
                             || ctrl_wr;
        end
    end

    // response waits for both halves, which may come in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rlsc_pkg::RESP_OKAY;
        end else if (ctrl_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_ctrl(awaddr_ff) ? rlsc_pkg::RESP_OKAY
                                               : rlsc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register bus read side
    // ------------------------------------------------------------------
    // arready pulses once, so a held arvalid is taken only once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready
                             && s_axi_arvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= rlsc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (is_ctrl(s_axi_araddr)) begin
                // upper bits and reserved field read zero
                s_axi_rdata <= {24'h00_0000,
                                ctrl_ff & rlsc_pkg::CTRL_WRITE_MASK};
                s_axi_rresp <= rlsc_pkg::RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= rlsc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // window decode
    // ------------------------------------------------------------------
    logic        mem_on;
    logic [31:0] win_base;
    logic        local_hit;
    logic        plain_hit;

    // decode uses the register itself; the status copies lag one cycle
    // and only tell software what is in force
    assign mem_on   = ctrl_ff[rlsc_pkg::CTRL_ENABLE_BIT];
    assign win_base = ctrl_ff[rlsc_pkg::CTRL_HIGH_BIT]
                    ? rlsc_pkg::HIGH_WIN_BASE
                    : rlsc_pkg::LOW_WIN_BASE;
    assign local_hit = core_req && mem_on
                       && in_window(core_addr, win_base);
    // cache store as plain memory joins the high window
    assign plain_hit = core_req && cache_plain_mode
                       && in_window(core_addr,
                                    rlsc_pkg::PLAIN_WIN_BASE);

    // ------------------------------------------------------------------
    // segment match; overlapping segments are undefined, lowest wins
    // ------------------------------------------------------------------
    logic [rlsc_pkg::SEG_COUNT-1:0] seg_match;
    logic [DW-1:0]                  sel_desc;

    genvar s;
    generate
        for (s = 0; s < rlsc_pkg::SEG_COUNT; s++) begin : g_seg
            assign seg_match[s] =
                (seg_start[s*PB +: PB] <= core_addr[31:rlsc_pkg::PAGE_SHIFT])
             && (core_addr[31:rlsc_pkg::PAGE_SHIFT] < seg_stop[s*PB +: PB]);
        end
    endgenerate

    always_comb begin
        sel_desc = fallback_segment_descriptor;
        for (int i = rlsc_pkg::SEG_COUNT - 1; i >= 0; i--) begin
            if (seg_match[i]) begin
                sel_desc = segment_descriptor[i*DW +: DW];
            end
        end
    end

    logic access_ok;
    assign access_ok = priv_ok(sel_desc, core_user, core_we);

    // ------------------------------------------------------------------
    // local store
    // ------------------------------------------------------------------
    logic mem_wr;
    logic mem_rd;

    // a refused write never reaches the array
    assign mem_wr = local_hit && core_we && access_ok;
    // a refused read leaves the data pins at zero
    assign mem_rd = local_hit && !core_we && access_ok;

    // the store's read register drives the core data pins directly
    rlsc_mem u_mem (
        .aclk     (aclk),
        .wr_en    (mem_wr),
        .rd_en    (mem_rd),
        .byte_en  (core_be),
        .addr     (core_addr[rlsc_pkg::WIN_SHIFT-1:2]),
        .wdata    (core_wdata),
        .rdata_ff (core_rdata)
    );

    // ------------------------------------------------------------------
    // core answer: one edge after the request, no waits
    // ------------------------------------------------------------------
    // one-cycle pulses; a refused access still answers, so no hang
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ack   <= 1'b0;
            core_abort <= 1'b0;
        end else begin
            core_ack   <= local_hit && access_ok;
            core_abort <= local_hit && !access_ok;
        end
    end

    // ------------------------------------------------------------------
    // external path, taken only by accesses outside the local and plain windows
    // ------------------------------------------------------------------
    // payload copies run free; only ext_req qualifies them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_req         <= 1'b0;
            ext_we          <= 1'b0;
            ext_addr        <= 32'h0000_0000;
            ext_be          <= 4'h0;
            ext_wdata       <= 32'h0000_0000;
            ext_no_alloc    <= 1'b0;
            cache_plain_sel <= 1'b0;
        end else begin
            ext_req         <= core_req && !local_hit && !plain_hit;
            ext_we          <= core_we;
            ext_addr        <= core_addr;
            ext_be          <= core_be;
            ext_wdata       <= core_wdata;
            ext_no_alloc    <= local_hit || plain_hit;
            cache_plain_sel <= plain_hit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_enabled <= 1'b0;
            local_high    <= 1'b0;
        end else begin
            local_enabled <= mem_on;
            local_high    <= ctrl_ff[rlsc_pkg::CTRL_HIGH_BIT];
        end
    end

endmodule

/* File: logic/rlsc_pkg.sv */
package rlsc_pkg;

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_BASE_ADDR   = 32'hffffa404;
    localparam logic [31:0] CTRL_OFFSET      = 32'h0000_0000;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam int          CTRL_WIDTH       = 8;
    localparam int          CTRL_ENABLE_BIT  = 0;
    localparam int          CTRL_HIGH_BIT    = 1;
    localparam logic [7:0]  CTRL_WRITE_MASK  = 8'h03;

    // ------------------------------------------------------------------
    // address windows, all on 2 KB boundaries
    // ------------------------------------------------------------------
    localparam logic [31:0] LOW_WIN_BASE     = 32'h0000_0000;
    localparam logic [31:0] HIGH_WIN_BASE    = 32'h6000_0000;
    localparam logic [31:0] PLAIN_WIN_BASE   = 32'h6000_0800;
    localparam int          WIN_SHIFT        = 11;
    localparam int          WORD_ADDR_BITS   = 9;
    localparam int          MEM_WORDS        = 512;

    // ------------------------------------------------------------------
    // segments: 1 KB pages, privilege fields of a descriptor
    // ------------------------------------------------------------------
    localparam int          SEG_COUNT        = 8;
    localparam int          PAGE_SHIFT       = 10;
    localparam int          PAGE_BITS        = 22;
    localparam int          DESC_WIDTH       = 16;
    localparam int          PRIV_USER_RD     = 0;
    localparam int          PRIV_USER_WR     = 1;
    localparam int          PRIV_SYS_RD      = 2;
    localparam int          PRIV_SYS_WR      = 3;

    // ------------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

endpackage

/* File: logic/rlsc_mem.sv */
`timescale 1ns/1ps
module rlsc_mem (
    // clock
    input  wire logic                                 aclk,
    // access
    input  wire logic                                 wr_en,
    input  wire logic                                 rd_en,
    input  wire logic [3:0]                           byte_en,
    input  wire logic [rlsc_pkg::WORD_ADDR_BITS-1:0]  addr,
    input  wire logic [31:0]                          wdata,
    output logic      [31:0]                          rdata_ff
);

    logic [31:0] store [rlsc_pkg::MEM_WORDS];

    // ------------------------------------------------------------------
    // byte lanes
    // ------------------------------------------------------------------
    // all lanes in one process, so the array keeps a single driver
    always_ff @(posedge aclk) begin
        for (int lane = 0; lane < 4; lane++) begin
            if (wr_en && byte_en[lane]) begin
                store[addr][lane*8 +: 8] <= wdata[lane*8 +: 8];
            end
        end
    end

    // zero unless a granted read, so a refused read shows nothing
    always_ff @(posedge aclk) begin
        if (rd_en) begin
            rdata_ff <= store[addr];
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

endmodule

/* File: bench/rlsc_chk.sv */
`timescale 1ns/1ps
module rlsc_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // core side
    input wire logic        core_req,
    input wire logic        core_we,
    input wire logic [31:0] core_addr,
    input wire logic [3:0]  core_be,
    input wire logic [31:0] core_wdata,
    input wire logic        cache_plain_mode,
    input wire logic        core_ack,
    input wire logic        core_abort,
    input wire logic [31:0] core_rdata,
    input wire logic        cache_plain_sel,
    // external path and status
    input wire logic        ext_req,
    input wire logic [31:0] ext_addr,
    input wire logic        ext_we,
    input wire logic [3:0]  ext_be,
    input wire logic [31:0] ext_wdata,
    input wire logic        ext_no_alloc,
    input wire logic        local_enabled,
    input wire logic        local_high
);
    // ------------------------------------------------------------
    // window decode
    // ------------------------------------------------------------
    logic in_win;
    logic in_plain;
    logic hit;
    assign in_win = core_addr[31:11] == (local_high ?
        rlsc_pkg::HIGH_WIN_BASE[31:11] : rlsc_pkg::LOW_WIN_BASE[31:11]);
    assign in_plain = cache_plain_mode &&
        core_addr[31:11] == rlsc_pkg::PLAIN_WIN_BASE[31:11];
    assign hit = core_req && local_enabled && in_win;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // status copy lags the register, so both checks wait for it to settle
    chk_hit_answer: assert property (
        hit ##1 $stable(local_enabled) && $stable(local_high)
        |-> (core_ack ^ core_abort) && !ext_req)
        else $error("local hit not answered");
    chk_miss_forward: assert property (
        core_req && !(local_enabled && in_win) && !in_plain
        ##1 $stable(local_enabled) && $stable(local_high)
        |-> ext_req && ext_addr == $past(core_addr) && !core_ack
            && ext_we == $past(core_we) && ext_be == $past(core_be)
            && ext_wdata == $past(core_wdata))
        else $error("miss not forwarded");
    chk_ack_cause: assert property (
        core_ack || core_abort |-> $past(core_req))
        else $error("answer without request");
    chk_rdata_gate: assert property (
        !core_ack |-> core_rdata == 32'h0)
        else $error("read data not gated");
    chk_ctrl_reset: assert property (
        disable iff (1'b0) !aresetn |=> !local_enabled && !local_high)
        else $error("control not cleared by reset");
    chk_abort_excl: assert property (
        core_abort |-> !core_ack && !ext_req && !cache_plain_sel)
        else $error("abort not exclusive");
    chk_no_alloc: assert property (
        core_ack || core_abort |-> ext_no_alloc)
        else $error("local access cacheable");
    chk_plain_sel: assert property (
        core_req && in_plain |=> cache_plain_sel && !ext_req)
        else $error("plain region not selected");
endmodule
bind rlsc_top rlsc_chk u_chk (
    .aclk, .aresetn, .core_req, .core_addr, .cache_plain_mode, .core_ack,
    .core_abort, .core_rdata, .cache_plain_sel, .ext_req, .ext_addr,
    .ext_no_alloc, .local_enabled, .local_high, .core_we, .core_be,
    .core_wdata, .ext_we, .ext_be, .ext_wdata
);

/* File: bench/rlsc_core_model.sv */
`timescale 1ns/1ps
module rlsc_core_model (
    // clock
    input  wire logic        aclk,
    // request
    output logic             core_req,
    output logic             core_we,
    output logic             core_user,
    output logic [31:0]      core_addr,
    output logic [3:0]       core_be,
    output logic [31:0]      core_wdata,
    // answer
    input  wire logic        core_ack,
    input  wire logic        core_abort,
    input  wire logic [31:0] core_rdata,
    input  wire logic        ext_req,
    input  wire logic        cache_plain_sel
);
    initial begin
        {core_req, core_we, core_user} = 3'b000;
        {core_addr, core_wdata, core_be} = '0;
    end
    // ------------------------------------------------------------
    // one access, answer sampled in the cycle it stands
    // ------------------------------------------------------------
    task automatic access(input logic we, user, input logic [31:0] a, d,
                          output logic [3:0] fl, output logic [31:0] q);
        @(posedge aclk);
        core_req   <= 1'b1;
        core_we    <= we;
        core_user  <= user;
        core_addr  <= a;
        core_be    <= 4'hf;
        core_wdata <= d;
        @(posedge aclk);
        core_req   <= 1'b0;
        // released address and data lines show the inverse, never a stale copy
        core_addr  <= ~a;
        core_wdata <= ~d;
        #1;
        fl = {core_ack, core_abort, ext_req, cache_plain_sel};
        q  = core_rdata;
    endtask
endmodule

/* File: bench/rlsc_tb_top.sv */
`timescale 1ns/1ps
module rlsc_tb_top;
    localparam logic [31:0] CTRL = rlsc_pkg::CTRL_BASE_ADDR;
    localparam logic [31:0] HI   = rlsc_pkg::HIGH_WIN_BASE;
    localparam logic [31:0] PAT  = 32'h5a5a_0000;
    localparam logic [3:0]  ACK  = 4'h8;
    localparam logic [3:0]  ABT  = 4'h4;
    localparam logic [3:0]  EXT  = 4'h2;
    localparam logic [1:0]  OK   = rlsc_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR  = rlsc_pkg::RESP_SLVERR;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, core_req;
    logic        core_we, core_user, core_ack, core_abort, cache_plain_mode;
    logic        cache_plain_sel, ext_req, ext_no_alloc, local_enabled;
    logic        local_high, g;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb, core_be;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, m;
    logic [31:0] core_addr, core_wdata, core_rdata, ext_addr;
    logic [31:0] adr [4] = '{32'h0, 32'h4, 32'h7f8, 32'h7fc};
    logic [175:0] seg_start, seg_stop;
    logic [127:0] segment_descriptor;
    logic [15:0] fallback_segment_descriptor;
    int          fails, checks, idx;
    initial aclk = 1'b0;
    always #10 aclk = ~aclk;
    rlsc_top dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .core_req, .core_we, .core_user,
        .core_addr, .core_be, .core_wdata, .core_ack, .core_abort,
        .core_rdata, .seg_start, .seg_stop, .segment_descriptor,
        .fallback_segment_descriptor, .cache_plain_mode, .cache_plain_sel,
        .ext_req, .ext_we(), .ext_addr, .ext_be(), .ext_wdata(),
        .ext_no_alloc, .local_enabled, .local_high
    );
    rlsc_core_model core (
        .aclk, .core_req, .core_we, .core_user, .core_addr, .core_be,
        .core_wdata, .core_ack, .core_abort, .core_rdata, .ext_req,
        .cache_plain_sel
    );
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic cmp_val(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s,
                             input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata  <= d;
        s_axi_wstrb  <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        cmp_val({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic axi_read(input logic [31:0] a, ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        cmp_val(s_axi_rdata, ed);
        cmp_val({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic core_do(input logic we, user, input logic [31:0] a, d,
                           input logic [3:0] ef, input logic [31:0] eq);
        logic [3:0]  fl;
        logic [31:0] q;
        core.access(we, user, a, d, fl, q);
        cmp_val({28'h0, fl}, {28'h0, ef});
        cmp_val(q, eq);
    endtask
    task automatic complete_run;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        complete_run();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, cache_plain_mode} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        {seg_start, seg_stop, segment_descriptor} = '0;
        fallback_segment_descriptor = 16'h000f;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(CTRL, 32'h0, OK);
        core_do(1'b0, 1'b0, 32'h0, 32'h0, EXT, 32'h0);
        axi_write(CTRL, 32'hffff_fffd, 4'hf, OK);
        axi_read(CTRL, 32'h1, OK);
        axi_write(CTRL, 32'h2, 4'he, OK);
        axi_read(CTRL, 32'h1, OK);
        axi_write(CTRL + 32'h4, 32'h3, 4'hf, ERR);
        axi_read(CTRL + 32'h4, 32'h0, ERR);
        cmp_val({31'h0, local_enabled}, 32'h1);
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            core_do(1'b1, 1'b0, adr[i], adr[i] ^ PAT, ACK, 32'h0);
            core_do(1'b0, 1'b1, adr[i], 32'h0, ACK, adr[i] ^ PAT);
        end
        core_do(1'b0, 1'b0, 32'h800, 32'h0, EXT, 32'h0);
        axi_write(CTRL, 32'h3, 4'hf, OK);
        core_do(1'b0, 1'b0, 32'h4, 32'h0, EXT, 32'h0);
        cmp_val({31'h0, local_high}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            core_do(1'b0, 1'b0, HI | adr[i], 32'h0, ACK, adr[i] ^ PAT);
        end
        core_do(1'b0, 1'b0, HI | 32'h800, 32'h0, EXT, 32'h0);
        @(posedge aclk) cache_plain_mode <= 1'b1;
        core_do(1'b1, 1'b0, HI | 32'h800, 32'h0, 4'h1, 32'h0);
        @(posedge aclk) cache_plain_mode <= 1'b0;
        $display("window test done");
        m = 32'h1234_5678;
        core_do(1'b1, 1'b0, HI | 32'h10, m, ACK, 32'h0);
        for (int p = 0; p < 4; p++) begin
            @(posedge aclk) fallback_segment_descriptor <= 16'h1 << p;
            for (int k = 0; k < 4; k++) begin
                idx = k[1] ? k[0] : 2 + k[0];
                g = (idx == p);
                core_do(k[0], k[1], HI | 32'h10, 32'hbeef_0000 + k,
                        g ? ACK : ABT, (g && !k[0]) ? m : 32'h0);
                if (g && k[0]) m = 32'hbeef_0000 + k;
            end
        end
        @(posedge aclk) fallback_segment_descriptor <= 16'h000f;
        core_do(1'b0, 1'b1, HI | 32'h10, 32'h0, ACK, m);
        @(posedge aclk) seg_start[21:0] <= HI[31:10];
        seg_stop[21:0] <= HI[31:10] + 22'h2;
        segment_descriptor[15:0] <= 16'hfff0;
        core_do(1'b0, 1'b0, HI | 32'h10, 32'h0, ABT, 32'h0);
        @(posedge aclk) segment_descriptor[15:0] <= 16'h000c;
        core_do(1'b0, 1'b0, HI | 32'h10, 32'h0, ACK, m);
        core_do(1'b0, 1'b1, HI | 32'h10, 32'h0, ABT, 32'h0);
        $display("privilege test done");
        axi_write(CTRL, 32'h2, 4'hf, OK);
        core_do(1'b0, 1'b0, HI | 32'h10, 32'h0, EXT, 32'h0);
        axi_read(CTRL, 32'h2, OK);
        $display("disable test done");
        complete_run();
    end
endmodule
